//--- smc_main.sv
// standby mode controller: run, halt, hold and crystal-hold sequencing
// assumes: all inputs synchronous to clk; osc_wr pulses from a register
// outside; the core issues standby_req only while running
`timescale 1ns/100ps
`default_nettype none
`include "smc_params.svh"

module smc_main
  import smc_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      reset_pin_n,
  input  wire logic                      wdt_reset,
  input  wire smc_wake_s                 wake,
  input  wire logic                      standby_req,
  input  wire smc_req_e                  standby_mode,
  input  wire logic                      osc_wr,
  input  wire logic                      osc_cf_on,
  input  wire logic                      osc_xt_on,
  input  wire logic [`SMC_DIV_SEL_W-1:0] div_sel,
  output smc_mode_e                      mode,
  output smc_run_s                       run,
  output smc_osc_s                       osc,
  output logic                           sys_reset,
  output logic                           wake_irq,
  output logic                           cyc_tick
);

  smc_state_s s;
  smc_state_s next_s;
  logic       ext_wake;
  logic       hold_wake;
  logic       sys_rst_evt;
  logic       div_tick;

  // qualify external lines; edge-mode lines zero and one are masked
  smc_irq_qual #(
    .N_LINES (`SMC_EXT_LINES),
    .N_LVL   (`SMC_LVL_LINES)
  ) u_qual (
    .ext_irq   (wake.ext_irq),
    .ext_level (wake.ext_level),
    .ext_wake  (ext_wake)
  );

  // divider restarts with every system reset
  smc_cyc_div #(
    .BASE (`SMC_TCYC_BASE_CYC),
    .NSET (`SMC_DIV_SETTINGS)
  ) u_div (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (sys_reset),
    .sel   (div_sel),
    .tick  (div_tick)
  );

  // wake terms of each mode
  assign hold_wake   = ext_wake | wake.port0_irq;
  assign sys_rst_evt = !reset_pin_n | wdt_reset;

  // next state, then run and oscillator enables from the next mode
  always_comb begin
    next_s          = s;
    next_s.wake_irq = 1'b0;
    if (sys_rst_evt) begin
      // reset pin and watchdog win over every mode and every wake
      next_s.mode    = SMC_M_RESET;
      next_s.rst_cnt = `SMC_RST_CNT_W'(`SMC_RST_HOLD_CYC - 1);
      next_s.cf_on   = 1'b0;
      next_s.xt_on   = 1'b0;
    end else begin
      unique case (s.mode)
        SMC_M_RESET: begin
          if (s.rst_cnt == '0) next_s.mode = SMC_M_RUN;
          else next_s.rst_cnt = s.rst_cnt - 1'b1;
        end
        SMC_M_RUN: begin
          if (osc_wr) begin
            next_s.cf_on = osc_cf_on;
            next_s.xt_on = osc_xt_on;
          end
          if (standby_req) begin
            unique case (standby_mode)
              SMC_REQ_HALT:  next_s.mode = SMC_M_HALT;
              SMC_REQ_HOLD:  next_s.mode = SMC_M_HOLD;
              SMC_REQ_XHOLD: next_s.mode = SMC_M_XHOLD;
              default:       next_s.mode = SMC_M_RUN;
            endcase
          end
        end
        SMC_M_HALT: begin
          if (wake.irq_any) begin
            next_s.mode     = SMC_M_RUN;
            next_s.wake_irq = 1'b1;
          end
        end
        SMC_M_HOLD: begin
          if (hold_wake) begin
            next_s.mode     = SMC_M_RUN;
            next_s.wake_irq = 1'b1;
          end
        end
        SMC_M_XHOLD: begin
          if (hold_wake | wake.base_timer_irq | wake.ir_irq) begin
            next_s.mode     = SMC_M_RUN;
            next_s.wake_irq = 1'b1;
          end
        end
        default: next_s.mode = SMC_M_RESET;
      endcase
    end
    // who may run in each mode
    next_s.run.cpu        = (next_s.mode == SMC_M_RUN);
    next_s.run.periph     = (next_s.mode == SMC_M_RUN) ||
                            (next_s.mode == SMC_M_HALT);
    next_s.run.base_timer = next_s.run.periph ||
                            (next_s.mode == SMC_M_XHOLD);
    next_s.run.ir_rx      = next_s.run.base_timer;
    // flags survive standby, so oscillators come back as software left them
    next_s.osc.ceramic_oscillator = next_s.cf_on &&
                                    next_s.run.periph;
    next_s.osc.internal_rc_oscillator = next_s.run.periph ||
                                    (next_s.mode == SMC_M_RESET);
    next_s.osc.crystal = next_s.xt_on &&
                         (next_s.mode != SMC_M_HOLD);
  end

  // rc runs in reset so the chip has a clock to restart on
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '{mode: SMC_M_RESET, cf_on: 1'b0, xt_on: 1'b0,
             rst_cnt: '0, wake_irq: 1'b0,
             run: '0, osc: '{1'b0, 1'b1, 1'b0}};
    end else begin
      s <= next_s;
    end
  end

  assign mode      = s.mode;
  assign run       = s.run;
  assign osc       = s.osc;
  assign sys_reset = (s.mode == SMC_M_RESET);
  assign wake_irq  = s.wake_irq;
  // instruction ticks only count while the core executes
  assign cyc_tick  = div_tick & s.run.cpu;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic no_rst;
  assign no_rst = reset_pin_n && !wdt_reset;

  AST_HALT_PERIPH: assert property (
    mode == SMC_M_HALT |-> run.periph && !run.cpu)
    else $error("halt must stop cpu and keep peripherals");
  AST_HALT_OSC: assert property (
    mode == SMC_M_RUN && standby_req && standby_mode == SMC_REQ_HALT &&
    no_rst && !osc_wr |=> osc == $past(osc))
    else $error("halt entry changed an oscillator");
  AST_HALT_EXIT: assert property (
    mode == SMC_M_HALT && wake.irq_any && no_rst
      |=> mode == SMC_M_RUN && run.cpu && wake_irq)
    else $error("interrupt did not end halt");
  AST_HOLD_STOP: assert property (
    mode == SMC_M_HOLD |-> run == '0)
    else $error("hold must stop cpu and all peripherals");
  AST_HOLD_OSC: assert property (
    mode == SMC_M_HOLD |-> osc == '0)
    else $error("hold left an oscillator running");
  AST_HOLD_EXIT: assert property (
    mode == SMC_M_HOLD && (wake.port0_irq || wake.ext_irq[2]) && no_rst
      |=> mode == SMC_M_RUN)
    else $error("hold did not end on a hold wake source");
  AST_EDGE_NO_WAKE: assert property (
    mode == SMC_M_HOLD && no_rst && !wake.port0_irq &&
    wake.ext_irq[`SMC_EXT_LINES-1:`SMC_LVL_LINES] == '0 &&
    (wake.ext_irq[`SMC_LVL_LINES-1:0] & wake.ext_level) == '0
      |=> mode == SMC_M_HOLD)
    else $error("edge-mode line woke the chip from hold");
  AST_XHOLD_UNITS: assert property (
    mode == SMC_M_XHOLD |-> run.base_timer && run.ir_rx &&
    !run.periph && !run.cpu)
    else $error("crystal-hold run enables wrong");
  AST_XHOLD_OSC: assert property (
    mode == SMC_M_RUN && standby_req && standby_mode == SMC_REQ_XHOLD &&
    no_rst && !osc_wr |=> !osc.ceramic_oscillator &&
    !osc.internal_rc_oscillator && osc.crystal == $past(osc.crystal))
    else $error("crystal-hold entry oscillator state wrong");
  AST_XHOLD_EXIT: assert property (
    mode == SMC_M_XHOLD && (wake.base_timer_irq || wake.ir_irq) && no_rst
      |=> mode == SMC_M_RUN)
    else $error("base timer or ir did not end crystal-hold");
  AST_SYSRST_OSC: assert property (
    !no_rst |=> sys_reset && !osc.ceramic_oscillator && !osc.crystal)
    else $error("system reset left ceramic or crystal running");
  AST_RESET_RESTART: assert property (
    mode == SMC_M_RESET && $past(mode) != SMC_M_RESET && no_rst
      |-> ##3 (no_rst ##1 (mode == SMC_M_RUN && !wake_irq))
      or ##[0:4] !no_rst)
    else $error("reset did not restart into run");

  // run and oscillator enables per mode, checked every cycle rather than only at
  // entry, so a stray write to the state cannot go unnoticed
  AST_RUN_ALL: assert property (
    mode == SMC_M_RUN |-> run == '1)
    else $error("run mode must enable every unit");
  AST_RESET_QUIET: assert property (
    mode == SMC_M_RESET |-> run == '0 && sys_reset)
    else $error("reset state must stop every unit");
  AST_RC_HALT: assert property (
    mode == SMC_M_HALT |-> osc.internal_rc_oscillator)
    else $error("halt stopped the rc oscillator");
  AST_XHOLD_FAST_OFF: assert property (
    mode == SMC_M_XHOLD |-> !osc.ceramic_oscillator &&
    !osc.internal_rc_oscillator)
    else $error("crystal-hold left ceramic or rc running");
  AST_SYSRST_FLAGS: assert property (
    sys_reset |-> !osc.ceramic_oscillator && !osc.crystal)
    else $error("reset state left ceramic or crystal running");

  // each accepted request lands in its mode one clock later
  AST_HALT_ENTRY: assert property (
    mode == SMC_M_RUN && standby_req && standby_mode == SMC_REQ_HALT &&
    no_rst |=> mode == SMC_M_HALT)
    else $error("halt request not taken");
  AST_HOLD_ENTRY: assert property (
    mode == SMC_M_RUN && standby_req && standby_mode == SMC_REQ_HOLD &&
    no_rst |=> mode == SMC_M_HOLD)
    else $error("hold request not taken");
  AST_XHOLD_ENTRY: assert property (
    mode == SMC_M_RUN && standby_req && standby_mode == SMC_REQ_XHOLD &&
    no_rst |=> mode == SMC_M_XHOLD)
    else $error("crystal-hold request not taken");

  // oscillators hold still while a standby mode lasts; osc_wr is
  // refused outside run, so nothing may move them
  AST_HALT_OSC_KEPT: assert property (
    mode == SMC_M_HALT && $past(mode) == SMC_M_HALT |-> $stable(osc))
    else $error("oscillator moved during halt");
  AST_XHOLD_XT_KEPT: assert property (
    mode == SMC_M_XHOLD && $past(mode) == SMC_M_XHOLD
      |-> $stable(osc.crystal))
    else $error("crystal state moved during crystal-hold");

  // staying put without a wake source, leaving with one
  AST_HALT_STAYS: assert property (
    mode == SMC_M_HALT && !wake.irq_any && no_rst |=> mode == SMC_M_HALT)
    else $error("halt ended without a wake source");
  AST_HOLD_LEVEL_WAKE: assert property (
    mode == SMC_M_HOLD && no_rst &&
    (wake.ext_irq[`SMC_LVL_LINES-1:0] & wake.ext_level) != '0
      |=> mode == SMC_M_RUN)
    else $error("level-mode line did not end hold");
  AST_XHOLD_HOLD_SRC: assert property (
    mode == SMC_M_XHOLD && no_rst && (wake.port0_irq ||
    wake.ext_irq[`SMC_EXT_LINES-1:`SMC_LVL_LINES] != '0)
      |=> mode == SMC_M_RUN)
    else $error("hold wake source did not end crystal-hold");
  AST_XHOLD_STAYS: assert property (
    mode == SMC_M_XHOLD && no_rst && !wake.port0_irq &&
    !wake.base_timer_irq && !wake.ir_irq &&
    wake.ext_irq[`SMC_EXT_LINES-1:`SMC_LVL_LINES] == '0 &&
    (wake.ext_irq[`SMC_LVL_LINES-1:0] & wake.ext_level) == '0
      |=> mode == SMC_M_XHOLD)
    else $error("crystal-hold ended without a wake source");

  // a reset cause beats any wake in the same cycle; the wake pulse
  // is one clock long and only ever marks a return to run
  AST_RST_BEATS_WAKE: assert property (
    !no_rst |=> mode == SMC_M_RESET && !wake_irq)
    else $error("wake won over a system reset cause");
  AST_WAKE_RUN: assert property (
    wake_irq |-> mode == SMC_M_RUN && run.cpu)
    else $error("wake pulse outside run");
  AST_WAKE_ONE: assert property (
    wake_irq |=> !wake_irq)
    else $error("wake pulse longer than one clock");
  AST_NO_TICK_STOP: assert property (
    !run.cpu |-> !cyc_tick)
    else $error("instruction tick while execution stopped");

  COV_HALT_WAKE:  cover property (mode == SMC_M_HALT ##1 wake_irq);
  COV_HOLD_WAKE:  cover property (mode == SMC_M_HOLD ##1 wake_irq);
  COV_XHOLD_BT:   cover property (
    mode == SMC_M_XHOLD && wake.base_timer_irq ##1 mode == SMC_M_RUN);
  COV_WDT_RESET:  cover property (mode != SMC_M_RESET && wdt_reset);
  COV_HOLD_PORT0: cover property (
    mode == SMC_M_HOLD && wake.port0_irq ##1 mode == SMC_M_RUN);

endmodule : smc_main

`default_nettype wire

//--- smc_params.svh
// constants of the standby mode controller
// assumes: one 50 MHz clock, included by the package and design files
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH

// clock period and shortest instruction cycle, both in ns
`define SMC_CLK_PERIOD_NS 20
`define SMC_TCYC_MIN_NS   300
// shortest instruction cycle in clocks, rounded up as a least time
`define SMC_TCYC_BASE_CYC \
  ((`SMC_TCYC_MIN_NS + `SMC_CLK_PERIOD_NS - 1) / `SMC_CLK_PERIOD_NS)
// number of doubling divider settings, and select width
`define SMC_DIV_SETTINGS  9
`define SMC_DIV_SEL_W     4
`define SMC_DIV_CNT_W     12
// clocks for which the internal system reset is stretched
`define SMC_RST_HOLD_CYC  4
`define SMC_RST_CNT_W     3
// external interrupt lines, and how many of them need level detection
`define SMC_EXT_LINES     5
`define SMC_LVL_LINES     2

`endif

//--- smc_pkg.sv
// types shared by the standby mode controller files
// assumes: smc_params.svh sits in the same folder
`include "smc_params.svh"

package smc_pkg;

  // operating mode of the core
  typedef enum logic [2:0] {
    SMC_M_RESET,
    SMC_M_RUN,
    SMC_M_HALT,
    SMC_M_HOLD,
    SMC_M_XHOLD
  } smc_mode_e;

  // standby mode asked for by the core
  typedef enum logic [1:0] {
    SMC_REQ_HALT,
    SMC_REQ_HOLD,
    SMC_REQ_XHOLD
  } smc_req_e;

  // wake sources, all active-high levels
  typedef struct packed {
    logic [`SMC_EXT_LINES-1:0] ext_irq;     // lines zero,one,two,four,five
    logic [`SMC_LVL_LINES-1:0] ext_level;   // level mode, lines zero,one
    logic                      port0_irq;
    logic                      base_timer_irq;
    logic                      ir_irq;
    logic                      irq_any;     // any pending interrupt
  } smc_wake_s;

  // which parts of the chip are allowed to run
  typedef struct packed {
    logic cpu;
    logic periph;
    logic base_timer;
    logic ir_rx;
  } smc_run_s;

  // oscillator enables
  typedef struct packed {
    logic ceramic_oscillator;
    logic internal_rc_oscillator;
    logic crystal;
  } smc_osc_s;

  // state of the controller core
  typedef struct packed {
    smc_mode_e                 mode;
    logic                      cf_on;
    logic                      xt_on;
    logic [`SMC_RST_CNT_W-1:0] rst_cnt;
    logic                      wake_irq;
    smc_run_s                  run;
    smc_osc_s                  osc;
  } smc_state_s;

  // state of the cycle divider
  typedef struct packed {
    logic [`SMC_DIV_CNT_W-1:0] cnt;
    logic                      tick;
  } smc_div_s;

endpackage : smc_pkg

//--- smc_irq_qual.sv
// wake qualifier for the external interrupt lines of the hold modes
// assumes: inputs are synchronous levels; purely combinational
`timescale 1ns/100ps
`default_nettype none
`include "smc_params.svh"

module smc_irq_qual
  import smc_pkg::*;
#(
  parameter int N_LINES = `SMC_EXT_LINES,
  parameter int N_LVL   = `SMC_LVL_LINES
) (
  input  wire logic [N_LINES-1:0] ext_irq,
  input  wire logic [N_LVL-1:0]   ext_level,
  output logic                    ext_wake
);

  initial begin
    if (N_LVL > N_LINES || N_LINES < 1)
      $error("smc_irq_qual: bad line counts");
  end

  logic [N_LINES-1:0] allow;

  // edge-mode lines among the first N_LVL cannot wake a stopped chip
  always_comb begin
    allow = '1;
    for (int i = 0; i < N_LVL; i++) begin
      allow[i] = ext_level[i];
    end
    ext_wake = |(ext_irq & allow);
  end

endmodule : smc_irq_qual

`default_nettype wire

//--- smc_cyc_div.sv
// instruction cycle divider: one tick per instruction cycle
// assumes: sel is a level from the clock control; clear is a level held for as long as the system reset lasts
`timescale 1ns/100ps
`default_nettype none
`include "smc_params.svh"

module smc_cyc_div
  import smc_pkg::*;
#(
  parameter int BASE  = `SMC_TCYC_BASE_CYC,
  parameter int NSET  = `SMC_DIV_SETTINGS
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      clear,
  input  wire logic [`SMC_DIV_SEL_W-1:0] sel,
  output logic                           tick
);

  initial begin
    if (BASE < 1 || NSET < 1 ||
        BASE * (2 ** (NSET - 1)) > 2 ** `SMC_DIV_CNT_W)
      $error("smc_cyc_div: divider does not fit its counter");
  end

  smc_div_s                  s;
  smc_div_s                  next_s;
  logic [`SMC_DIV_SEL_W-1:0] sel_ok;
  logic [`SMC_DIV_CNT_W-1:0] lim;

  // out-of-range select falls back to the slowest setting
  always_comb begin
    sel_ok = (sel < NSET[`SMC_DIV_SEL_W-1:0]) ? sel
                                              : NSET[`SMC_DIV_SEL_W-1:0] - 1'b1;
    lim    = (BASE[`SMC_DIV_CNT_W-1:0] << sel_ok) - 1'b1;
    next_s = s;
    next_s.tick = 1'b0;
    if (clear) begin
      next_s.cnt = '0;
    end else if (s.cnt >= lim) begin
      next_s.cnt  = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) s <= '0;
    else        s <= next_s;
  end

  assign tick = s.tick;

  // helper: gap between ticks while sel holds still
  logic [`SMC_DIV_CNT_W-1:0] gap;
  logic                      seen;
  logic                      moved;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gap   <= '0;
      seen  <= 1'b0;
      moved <= 1'b0;
    end else begin
      gap   <= tick ? '0 : gap + 1'b1;
      seen  <= seen | tick;
      moved <= tick ? 1'b0 : (moved | clear | (sel != $past(sel)));
    end
  end

  AST_DIV_PERIOD: assert property (@(posedge clk) disable iff (!rst_n)
    tick && seen && !moved && !clear && sel == $past(sel)
      |-> gap == lim)
    else $error("cycle tick spacing wrong for divider setting");

endmodule : smc_cyc_div

`default_nettype wire

//--- smc_partner.sv
// far-side model: interrupt sources, reset pin and watchdog
// assumes: go is a one-clock pulse with src, lag and hold settled
`timescale 1ns/100ps
`default_nettype none

module smc_partner
  import smc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [3:0] src,
  input  wire logic [7:0] lag,
  input  wire logic [7:0] hold,
  input  wire logic [1:0] ext_level,
  output smc_wake_s       wake,
  output logic            reset_pin_n,
  output logic            wdt_reset,
  output logic            busy
);
  logic [7:0] cnt_lag = 8'h00;
  logic [7:0] cnt_on  = 8'h00;
  logic [3:0] cur     = 4'h0;
  logic       on;

  // a source waits lag clocks, then stands hold clocks and drops
  always @(posedge clk) begin
    if (go) begin
      cur <= src;
      cnt_lag <= lag;
      cnt_on <= hold;
    end else if (cnt_lag != 8'h00)
      cnt_lag <= cnt_lag - 8'h01;
    else if (cnt_on != 8'h00)
      cnt_on <= cnt_on - 8'h01;
  end

  // codes: 0-4 ext lines, 5 port0, 6 base timer, 7 ir, 8 pin, 9 wdt
  assign on = cnt_lag == 8'h00 && cnt_on != 8'h00;
  assign busy = cnt_lag != 8'h00 || cnt_on != 8'h00;
  assign wake.ext_irq = on && cur < 4'h5 ? 5'h01 << cur : 5'h00;
  assign wake.ext_level = ext_level;
  assign wake.port0_irq = on && cur == 4'h5;
  assign wake.base_timer_irq = on && cur == 4'h6;
  assign wake.ir_irq = on && cur == 4'h7;
  // every interrupt source also shows as pending; 0xa is pending alone
  assign wake.irq_any = on && (cur < 4'h8 || cur == 4'ha);
  assign reset_pin_n = !(on && cur == 4'h8);
  assign wdt_reset = on && cur == 4'h9;
endmodule : smc_partner
`default_nettype wire

//--- smc_main_bench.sv
// self-checking bench of the standby mode controller
// assumes: smc_pkg and smc_partner compiled first
`timescale 1ns/100ps
`default_nettype none

module smc_main_bench
  import smc_pkg::*;
;
  localparam int BASE = 300 / 20;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       standby_req = 1'b0;
  smc_req_e   standby_mode = SMC_REQ_HALT;
  logic       osc_wr = 1'b0, osc_cf_on = 1'b0, osc_xt_on = 1'b0;
  logic [3:0] div_sel = 4'h0;
  logic       go = 1'b0;
  logic [3:0] src = 4'h0;
  logic [7:0] lag = 8'h00, hold = 8'h00;
  logic [1:0] lvl = 2'h0;
  smc_wake_s  wake;
  logic       reset_pin_n, wdt_reset, busy, sys_reset, wake_irq, cyc_tick;
  smc_mode_e  mode;
  smc_run_s   run;
  smc_osc_s   osc;
  int         n_mismatch = 0;
  int         num_checks = 0;

  always #10 clk = ~clk;

  smc_main DUT (.clk(clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
    .wdt_reset(wdt_reset), .wake(wake), .standby_req(standby_req),
    .standby_mode(standby_mode), .osc_wr(osc_wr), .osc_cf_on(osc_cf_on),
    .osc_xt_on(osc_xt_on), .div_sel(div_sel), .mode(mode), .run(run),
    .osc(osc), .sys_reset(sys_reset), .wake_irq(wake_irq),
    .cyc_tick(cyc_tick));

  smc_partner FAR (.clk(clk), .go(go), .src(src), .lag(lag), .hold(hold),
    .ext_level(lvl), .wake(wake), .reset_pin_n(reset_pin_n),
    .wdt_reset(wdt_reset), .busy(busy));

  // inputs always move 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic note(input string w, input logic [15:0] e, g);
    num_checks++;
    if (e !== g) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask : note

  task automatic chk_mode(input string w, input smc_mode_e e);
    note(w, 16'(e), 16'(mode));
  endtask : chk_mode

  task automatic chk_run(input string w, input smc_run_s e);
    note(w, 16'(e), 16'(run));
  endtask : chk_run

  task automatic chk_osc(input string w, input smc_osc_s e);
    note(w, 16'(e), 16'(osc));
  endtask : chk_osc

  task automatic chk_bit(input string w, input logic e, g);
    note(w, 16'(e), 16'(g));
  endtask : chk_bit

  // request pulse, then one clock so the next request is a new pulse
  task automatic enter(input smc_req_e m);
    standby_mode = m;
    standby_req = 1'b1;
    step(1);
    standby_req = 1'b0;
    step(1);
  endtask : enter

  task automatic fire(input logic [3:0] s, input logic [7:0] l, h);
    src = s;
    lag = l;
    hold = h;
    go = 1'b1;
    step(1);
    go = 1'b0;
  endtask : fire

  task automatic idle;
    for (int i = 0; i < 300 && busy; i++) step(1);
  endtask : idle

  task automatic wait_mode(input smc_mode_e m, input int lim);
    for (int i = 0; i < lim && mode !== m; i++) step(1);
    chk_mode("awaited mode", m);
  endtask : wait_mode

  task automatic load_osc(input logic cf, xt);
    osc_cf_on = cf;
    osc_xt_on = xt;
    osc_wr = 1'b1;
    step(1);
    osc_wr = 1'b0;
  endtask : load_osc

  task automatic t_halt;
    load_osc(1'b1, 1'b1);
    enter(smc_req_e'(2'h3));
    chk_mode("code three", SMC_M_RUN);
    enter(SMC_REQ_HALT);
    chk_run("halt run", 4'h7);
    chk_osc("halt osc", 3'h7);
    enter(SMC_REQ_HOLD);
    chk_mode("request while halted", SMC_M_HALT);
    fire(4'ha, 8'h05, 8'h03);
    wait_mode(SMC_M_RUN, 12);
    chk_bit("wake pulse", 1'b1, wake_irq);
    step(1);
    chk_bit("wake pulse end", 1'b0, wake_irq);
    idle;
    $display("test halt done");
  endtask : t_halt

  task automatic t_hold;
    enter(SMC_REQ_HOLD);
    chk_run("hold run", 4'h0);
    chk_osc("hold osc", 3'h0);
    fire(4'h6, 8'h00, 8'h04);
    idle;
    chk_mode("base timer in hold", SMC_M_HOLD);
    lvl = 2'b10;
    fire(4'h0, 8'h00, 8'h04);
    idle;
    chk_mode("edge line zero", SMC_M_HOLD);
    fire(4'h1, 8'h00, 8'h03);
    wait_mode(SMC_M_RUN, 8);
    chk_osc("osc after hold", 3'h7);
    idle;
    // lines two, four, five and port 0
    for (int s = 2; s < 6; s++) begin
      enter(SMC_REQ_HOLD);
      fire(4'(s), 8'h02, 8'h03);
      wait_mode(SMC_M_RUN, 10);
      idle;
    end
    $display("test hold done");
  endtask : t_hold

  task automatic t_xhold;
    for (int s = 6; s < 8; s++) begin
      load_osc(1'b1, s[0]);
      enter(SMC_REQ_XHOLD);
      chk_run("xhold run", 4'h3);
      chk_osc("xhold osc", {2'b00, s[0]});
      fire(4'(s), 8'h01, 8'h03);
      wait_mode(SMC_M_RUN, 10);
      idle;
    end
    $display("test crystal hold done");
  endtask : t_xhold

  task automatic t_sysrst;
    enter(SMC_REQ_XHOLD);
    fire(4'h0, 8'h00, 8'h04);
    idle;
    chk_mode("edge zero in xhold", SMC_M_XHOLD);
    // reset pin from crystal hold, watchdog from halt
    for (int s = 8; s < 10; s++) begin
      enter(s == 8 ? SMC_REQ_XHOLD : SMC_REQ_HALT);
      fire(4'(s), 8'h00, 8'h01);
      step(2);
      chk_mode("reset wake", SMC_M_RESET);
      chk_bit("system reset", 1'b1, sys_reset);
      chk_osc("reset osc", 3'h2);
      wait_mode(SMC_M_RUN, 12);
      chk_bit("no wake pulse", 1'b0, wake_irq);
      chk_osc("osc after reset", 3'h2);
      idle;
    end
    $display("test system reset done");
  endtask : t_sysrst

  task automatic t_div;
    int n;
    for (int s = 0; s < 9; s++) begin
      div_sel = 4'(s);
      repeat (3) begin
        n = 0;
        do begin
          step(1);
          n++;
        end while (cyc_tick !== 1'b1 && n < 5000);
      end
      note("tick gap", 16'(BASE << s), 16'(n));
    end
    $display("test divider done");
  endtask : t_div

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  // main sequence: reset state, then each standby mode in turn
  initial begin
    step(4);
    chk_mode("in reset", SMC_M_RESET);
    chk_run("reset run", 4'h0);
    chk_osc("reset osc", 3'h2);
    rst_n = 1'b1;
    wait_mode(SMC_M_RUN, 8);
    chk_run("run all", 4'hf);
    $display("test reset done");
    t_halt;
    t_hold;
    t_xhold;
    t_sysrst;
    t_div;
    close_out;
  end

  // the run needs about 23000 clocks
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    close_out;
  end
endmodule : smc_main_bench
`default_nettype wire
